// File: core/ckg_pkg.sv
// Shared constants of the clock generator serial configuration port.
package ckg_pkg;
	// Slave address, write and read.
	localparam logic [7:0] ADDR_WR = 8'hD2;
	localparam logic [7:0] ADDR_RD = 8'hD3;
	// Command code: bit 7 picks byte mode, bits 6:0 the offset.
	localparam int CMD_BYTE_BIT = 7;
	// Control bytes and the block read count.
	localparam int NUM_REGS = 3;
	localparam logic [7:0] BLOCK_COUNT = 8'h03;
	// Control byte offsets.
	localparam logic [6:0] OFS_SRC = 7'h00;
	localparam logic [6:0] OFS_REF_CPU = 7'h01;
	localparam logic [6:0] OFS_PCI = 7'h02;
	// Power-up values of the control bytes.
	localparam logic [7:0] RST_SRC = 8'hFF;
	localparam logic [7:0] RST_REF_CPU = 8'hFE;
	localparam logic [7:0] RST_PCI = 8'hFF;
	// Writable bits; others keep power-up.
	localparam logic [7:0] WR_SRC = 8'h1F;
	localparam logic [7:0] WR_REF_CPU = 8'hF7;
	localparam logic [7:0] WR_PCI = 8'hFE;
	// Field positions inside control byte 1 and byte 2.
	localparam int POS_CRYSTAL_COPY_OUT_1 = 7;
	localparam int POS_CRYSTAL_COPY_OUT_0 = 6;
	localparam int POS_CPU3 = 5;
	localparam int POS_CPU2 = 4;
	localparam int POS_CPU1 = 2;
	localparam int POS_CPU0 = 1;
	localparam int POS_SPREAD = 0;
	localparam int POS_PCI_LSB = 4;
	localparam int POS_FREE_LSB = 1;
	// Host register offsets on the APB side.
	localparam logic [7:0] HREG_CTRL = 8'h00;
	localparam logic [7:0] HREG_CMD = 8'h04;
	localparam logic [7:0] HREG_TX = 8'h08;
	localparam logic [7:0] HREG_RX = 8'h0C;
	localparam logic [7:0] HREG_STAT = 8'h10;
	// Host field positions.
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_SKIP = 3;
	localparam int CMD_LEN_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_CNT_LSB = 8;
	// Host transfer kinds.
	typedef enum logic [1:0] {
		OP_BYTE_WR = 2'b00,
		OP_BYTE_RD = 2'b01,
		OP_BLK_WR = 2'b10,
		OP_BLK_RD = 2'b11
	} ckg_op_e;
	// Bytes the host can move in one block transfer.
	localparam int MAX_BLOCK = 4;
	// Serial clock quarter, rounded up.
	localparam int CLK_NS = 5;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_NS - 1)
		/ (4 * CLK_NS);
endpackage

// File: core/ckg_if.sv
// Two-wire link between host and clock generator, open drain.
`timescale 1ns/1ps
interface ckg_if;
	// Host drives the clock; both ends may pull the data line low.
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	// Resolved wire levels with pull-ups.
	logic scl;
	logic sda;
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1)
		& (dev_sda_oe ? dev_sda_o : 1'b1);
	// Host end.
	modport host (output host_scl_o, host_scl_oe, host_sda_o,
		host_sda_oe, input scl, sda);
	// Clock generator end.
	modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// File: core/ckg_dev.sv
// Clock generator end: serial slave and three output control bytes.
//
// How it works
// RULE1 - start, address, write, command, all acknowledged
// RULE2 - block write count byte, skippable
// RULE3 - slave acknowledges every block write byte
// RULE4 - block read restarts with read address
// RULE5 - block read sends count, then bytes
// RULE6 - host acknowledges all but last, then stops
// RULE7 - byte write: one data byte, ack, stop
// RULE8 - byte read: one byte, host nacks, stops
// RULE9 - serial ref and CPU pair enables
// RULE10 - crystal copy output enables, bit 3 reserved
// RULE11 - main synth loop spread, off at power-up
// RULE12 - bus clock and free-running enables
// RULE13 - command bit 7 picks byte or block
// RULE14 - answer only slave address D2h
// RULE15 - block bytes ascending, stop after any byte
// RULE16 - foreign address: no acknowledge, line released
// RULE17 - reserved bits ignore writes, read power-up
`timescale 1ns/1ps
module ckg_dev (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_srst,
	// Serial link.
	ckg_if.dev link,
	// Option that drops the count byte of block writes.
	input wire logic i_count_skip,
	// Output enables and spread control.
	output logic [4:0] o_serial_ref_pair_en,
	output logic [3:0] o_cpu_pair_en,
	output logic [1:0] o_crystal_copy_out_en,
	output logic [3:0] o_bus_clock_en,
	output logic [2:0] o_free_running_bus_clock_en,
	output logic o_main_synth_loop_spread
);
	// Protocol states, Gray along receive, ack, send, host ack.
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_RECV = 3'b001,
		D_SACK = 3'b011,
		D_SEND = 3'b010,
		D_HACK = 3'b110
	} ckg_dst_e;

	// Power-up value of a control byte.
	function automatic logic [7:0] rst_val(input logic [6:0] ofs);
		unique case (ofs)
			ckg_pkg::OFS_SRC: rst_val = ckg_pkg::RST_SRC;
			ckg_pkg::OFS_REF_CPU: rst_val = ckg_pkg::RST_REF_CPU;
			ckg_pkg::OFS_PCI: rst_val = ckg_pkg::RST_PCI;
			default: rst_val = 8'h00;
		endcase
	endfunction

	// Writable bits of a control byte.
	function automatic logic [7:0] wr_mask(input logic [6:0] ofs);
		unique case (ofs)
			ckg_pkg::OFS_SRC: wr_mask = ckg_pkg::WR_SRC;
			ckg_pkg::OFS_REF_CPU: wr_mask = ckg_pkg::WR_REF_CPU;
			ckg_pkg::OFS_PCI: wr_mask = ckg_pkg::WR_PCI;
			default: wr_mask = 8'h00;
		endcase
	endfunction

	// Pin samplers; index 0 is clock, 1 is data.
	logic [1:0] pin_in;
	logic [1:0] pin_q;
	logic [1:0] pin_prev_q;
	assign pin_in = {link.sda, link.scl};

	// Three flops per pin; a level counts once stages 2 and 3 agree.
	for (genvar g = 0; g < 2; g++) begin : g_sync
		logic [2:0] sync_q;
		always_ff @(posedge i_mclk) begin
			if (i_srst) begin
				sync_q <= 3'h7;
				pin_q[g] <= 1'b1;
				pin_prev_q[g] <= 1'b1;
			end else begin
				sync_q <= {sync_q[1:0], pin_in[g]};
				if (sync_q[2] == sync_q[1]) begin
					pin_q[g] <= sync_q[2];
				end
				pin_prev_q[g] <= pin_q[g];
			end
		end
	end

	// Link events from the filtered levels.
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = pin_q[0] & ~pin_prev_q[0];
	assign scl_fall = ~pin_q[0] & pin_prev_q[0];
	assign bus_start = pin_q[0] & pin_prev_q[0] & pin_prev_q[1] & ~pin_q[1];
	assign bus_stop = pin_q[0] & pin_prev_q[0] & ~pin_prev_q[1] & pin_q[1];

	// Protocol state.
	ckg_dst_e state_q;
	logic [3:0] bit_cnt_q; // Bits moved in the current byte.
	logic [7:0] shift_q; // Received or outgoing byte.
	logic [1:0] byte_idx_q; // 0 address, 1 command, 2 first, 3 later.
	logic [6:0] ptr_q; // Control byte offset in use.
	logic read_q; // Address carried the read bit.
	logic block_q; // Command asked for a block transfer.
	logic cnt_sent_q; // Block read count already sent.
	logic sda_oe_q; // Pulling the data line low.
	logic [7:0] regs_q [ckg_pkg::NUM_REGS];

	// Byte at the pointer; zero past the last.
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < ckg_pkg::NUM_REGS; i++) begin
			if (ptr_q == 7'(i)) begin
				rd_byte = regs_q[i];
			end
		end
	end

	// A received byte is complete at the fall after its eighth bit.
	logic byte_done;
	logic count_phase;
	logic wr_en;
	assign byte_done = (state_q == D_RECV) && scl_fall && (bit_cnt_q == 4'd8);
	// RULE2 - count byte phase
	assign count_phase = block_q && !i_count_skip && (byte_idx_q == 2'd2);
	// RULE3 - data byte writes
	assign wr_en = byte_done && !read_q && (byte_idx_q >= 2'd2)
		&& !count_phase;

	// Protocol engine: receive, acknowledge and send bytes.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_q <= D_IDLE;
			bit_cnt_q <= 4'd0;
			shift_q <= 8'h00;
			byte_idx_q <= 2'd0;
			ptr_q <= 7'h00;
			read_q <= 1'b0;
			block_q <= 1'b0;
			cnt_sent_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (bus_start) begin
			// RULE4 - start or repeated start
			state_q <= D_RECV;
			bit_cnt_q <= 4'd0;
			byte_idx_q <= 2'd0;
			sda_oe_q <= 1'b0;
		end else if (bus_stop) begin
			// RULE15 - stop after any byte
			state_q <= D_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				D_IDLE: begin
					// Released; waiting for a start.
					sda_oe_q <= 1'b0;
				end
				D_RECV: begin
					// Sample data on each rising clock, MSB first.
					if (scl_rise && bit_cnt_q < 4'd8) begin
						shift_q <= {shift_q[6:0], pin_q[1]};
						bit_cnt_q <= bit_cnt_q + 4'd1;
					end
					if (byte_done) begin
						if (byte_idx_q != 2'd3) begin
							byte_idx_q <= byte_idx_q + 2'd1;
						end
						state_q <= D_SACK;
						sda_oe_q <= 1'b1;
						if (byte_idx_q == 2'd0) begin
							// RULE14 - own address only
							if (shift_q == ckg_pkg::ADDR_WR) begin
								read_q <= 1'b0;
							end else if (shift_q == ckg_pkg::ADDR_RD) begin
								read_q <= 1'b1;
							end else begin
								// RULE16 - foreign address ignored
								state_q <= D_IDLE;
								sda_oe_q <= 1'b0;
							end
						end else if (byte_idx_q == 2'd1) begin
							// RULE13 - command decode
							block_q <= ~shift_q[ckg_pkg::CMD_BYTE_BIT];
							ptr_q <= shift_q[ckg_pkg::CMD_BYTE_BIT]
								? shift_q[6:0] : 7'h00;
							cnt_sent_q <= 1'b0;
						end else if (wr_en && ptr_q != 7'h7F) begin
							// RULE15 - ascending offsets
							ptr_q <= ptr_q + 7'h01;
						end
					end
				end
				D_SACK: begin
					// RULE1 - hold acknowledge until the next clock fall
					if (scl_fall) begin
						if (read_q) begin
							state_q <= D_SEND;
							bit_cnt_q <= 4'd1;
							if (block_q && !cnt_sent_q) begin
								// RULE5 - count byte first
								cnt_sent_q <= 1'b1;
								shift_q <= ckg_pkg::BLOCK_COUNT;
								sda_oe_q <= ~ckg_pkg::BLOCK_COUNT[7];
							end else begin
								// RULE8 - data byte at the pointer
								shift_q <= rd_byte;
								sda_oe_q <= ~rd_byte[7];
								if (ptr_q != 7'h7F) begin
									ptr_q <= ptr_q + 7'h01;
								end
							end
						end else begin
							state_q <= D_RECV;
							bit_cnt_q <= 4'd0;
							sda_oe_q <= 1'b0;
						end
					end
				end
				D_SEND: begin
					// Shift the next bit out after each falling clock.
					if (scl_fall) begin
						if (bit_cnt_q == 4'd8) begin
							state_q <= D_HACK;
							sda_oe_q <= 1'b0;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sda_oe_q <= ~shift_q[6];
							bit_cnt_q <= bit_cnt_q + 4'd1;
						end
					end
				end
				D_HACK: begin
					// RULE6 - host nack ends the read
					if (scl_rise) begin
						state_q <= pin_q[1] ? D_IDLE : D_SACK;
					end
				end
			endcase
		end
	end

	// Control bytes; reserved bits keep their power-up value.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			for (int i = 0; i < ckg_pkg::NUM_REGS; i++) begin
				regs_q[i] <= rst_val(7'(i));
			end
		end else begin
			for (int i = 0; i < ckg_pkg::NUM_REGS; i++) begin
				// RULE17 - masked write
				if (wr_en && ptr_q == 7'(i)) begin
					regs_q[i] <= (shift_q & wr_mask(7'(i)))
						| (regs_q[i] & ~wr_mask(7'(i)));
				end
			end
		end
	end

	// Open drain: low when enabled.
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe_q;

	// RULE9 - serial ref and CPU pair enables
	assign o_serial_ref_pair_en = regs_q[0][4:0];
	assign o_cpu_pair_en = {regs_q[1][ckg_pkg::POS_CPU3],
		regs_q[1][ckg_pkg::POS_CPU2], regs_q[1][ckg_pkg::POS_CPU1],
		regs_q[1][ckg_pkg::POS_CPU0]};
	// RULE10 - crystal copy outputs
	assign o_crystal_copy_out_en = {regs_q[1][ckg_pkg::POS_CRYSTAL_COPY_OUT_1],
		regs_q[1][ckg_pkg::POS_CRYSTAL_COPY_OUT_0]};
	// RULE11 - spread control
	assign o_main_synth_loop_spread = regs_q[1][ckg_pkg::POS_SPREAD];
	// RULE12 - bus clock enables
	assign o_bus_clock_en = regs_q[2][ckg_pkg::POS_PCI_LSB +: 4];
	assign o_free_running_bus_clock_en =
		regs_q[2][ckg_pkg::POS_FREE_LSB +: 3];
endmodule // ckg_dev

// File: core/ckg_host.sv
// Host end: APB-programmed serial master.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module ckg_host #(
	parameter int QUARTER_CYC = ckg_pkg::SCL_QUARTER_CYC
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_srst,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Serial link.
	ckg_if.host link
);
	// Sync needs several cycles a quarter.
	if (QUARTER_CYC < 4) begin : g_bad_quarter
		$error("QUARTER_CYC must be at least 4");
	end

	// Engine states, Gray along load, start, byte, stop.
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LOAD = 3'b001,
		H_START = 3'b011,
		H_BYTE = 3'b010,
		H_STOP = 3'b110
	} ckg_hst_e;
	// Kinds of sequence item.
	typedef enum logic [2:0] {
		IT_WR, IT_RD_ACK, IT_RD_NACK, IT_RESTART, IT_STOP
	} ckg_item_e;

	// Software registers.
	ckg_pkg::ckg_op_e op_q;
	logic skip_q;
	logic [7:0] cmd_q;
	logic [2:0] len_q;
	logic [31:0] tx_q;
	logic [31:0] rx_q;
	logic [7:0] rx_cnt_q;
	logic nack_q;
	// Engine.
	ckg_hst_e state_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [3:0] step_q;
	logic [7:0] byte_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic [15:0] div_q;
	logic tick;

	// Done at the edge that sees pready high.
	logic apb_done;
	logic go;
	assign apb_done = i_psel & i_penable & o_pready;
	assign go = apb_done && i_pwrite && i_paddr == ckg_pkg::HREG_CTRL
		&& i_pwdata[ckg_pkg::CTRL_GO] && state_q == H_IDLE;

	// APB answer one cycle into the access phase.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & i_penable & ~o_pready;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
			if (i_psel & i_penable & ~o_pready) begin
				unique case (i_paddr)
					ckg_pkg::HREG_CTRL: o_prdata <= 32'({skip_q, op_q, 1'b0});
					ckg_pkg::HREG_CMD: o_prdata <= 32'({len_q, cmd_q});
					ckg_pkg::HREG_TX: o_prdata <= tx_q;
					ckg_pkg::HREG_RX: o_prdata <= rx_q;
					ckg_pkg::HREG_STAT: o_prdata <= 32'({rx_cnt_q, 6'h00,
						nack_q, state_q != H_IDLE});
					default: o_pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Register writes; CTRL only while idle.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			op_q <= ckg_pkg::OP_BYTE_WR;
			skip_q <= 1'b0;
			cmd_q <= 8'h00;
			len_q <= 3'h0;
			tx_q <= 32'h0000_0000;
		end else if (apb_done && i_pwrite) begin
			if (go) begin
				op_q <= ckg_pkg::ckg_op_e'(i_pwdata[ckg_pkg::CTRL_OP_LSB +: 2]);
				skip_q <= i_pwdata[ckg_pkg::CTRL_SKIP];
			end
			if (i_paddr == ckg_pkg::HREG_CMD) begin
				cmd_q <= i_pwdata[7:0];
				len_q <= (i_pwdata[ckg_pkg::CMD_LEN_LSB +: 3] > 3'(ckg_pkg::MAX_BLOCK))
					? 3'(ckg_pkg::MAX_BLOCK) : i_pwdata[ckg_pkg::CMD_LEN_LSB +: 3];
			end
			if (i_paddr == ckg_pkg::HREG_TX) begin
				tx_q <= i_pwdata;
			end
		end
	end

	// Data pin: three flops, taken when 2 and 3 agree.
	logic [2:0] sda_sync_q;
	logic sda_q;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			sda_sync_q <= 3'h7;
			sda_q <= 1'b1;
		end else begin
			sda_sync_q <= {sda_sync_q[1:0], link.sda};
			if (sda_sync_q[2] == sda_sync_q[1]) begin
				sda_q <= sda_sync_q[2];
			end
		end
	end

	// Quarter-period enable pulses for the serial clock.
	always_ff @(posedge i_mclk) begin
		if (i_srst || div_q == 16'(QUARTER_CYC - 1)) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	assign tick = div_q == 16'(QUARTER_CYC - 1);

	// Sequence item for the current step.
	logic blk;
	logic rd;
	logic [2:0] n_data;
	logic [3:0] d_idx;
	ckg_item_e item;
	logic [7:0] item_byte;
	always_comb begin
		blk = op_q[1];
		rd = op_q[0];
		n_data = blk ? len_q : 3'h1;
		item = IT_STOP;
		item_byte = 8'h00;
		d_idx = 4'h0;
		if (step_q == 4'd0) begin
			// RULE1 - address with write bit
			item = IT_WR;
			item_byte = ckg_pkg::ADDR_WR;
		end else if (step_q == 4'd1) begin
			item = IT_WR;
			item_byte = cmd_q;
		end else if (!rd) begin
			// RULE2 - optional count byte
			if (blk && !skip_q && step_q == 4'd2) begin
				item = IT_WR;
				item_byte = 8'(len_q);
			end else begin
				// RULE7 - data bytes then stop
				d_idx = step_q - ((blk && !skip_q) ? 4'd3 : 4'd2);
				if (d_idx < 4'(n_data)) begin
					item = IT_WR;
					item_byte = tx_q[d_idx[1:0] * 8 +: 8];
				end
			end
		end else if (step_q == 4'd2) begin
			// RULE4 - repeated start then read address
			item = IT_RESTART;
		end else if (step_q == 4'd3) begin
			item = IT_WR;
			item_byte = ckg_pkg::ADDR_RD;
		end else if (blk && step_q == 4'd4) begin
			item = IT_RD_ACK;
		end else begin
			// RULE6 - last read byte gets a nack
			d_idx = step_q - (blk ? 4'd5 : 4'd4);
			if (d_idx < 4'(n_data)) begin
				item = (d_idx == 4'(n_data) - 4'd1) ? IT_RD_NACK : IT_RD_ACK;
			end
		end
	end

	// Serial engine: four quarters a bit.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_q <= H_IDLE;
			qtr_q <= 2'd0;
			bit_q <= 4'd0;
			step_q <= 4'd0;
			byte_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_q <= 1'b0;
			rx_q <= 32'h0000_0000;
			rx_cnt_q <= 8'h00;
		end else if (state_q == H_IDLE) begin
			if (go) begin
				state_q <= H_LOAD;
				step_q <= 4'd0;
				nack_q <= 1'b0;
			end
		end else if (state_q == H_LOAD) begin
			// Pick the slot kind for the new item.
			qtr_q <= 2'd0;
			bit_q <= 4'd0;
			byte_q <= item_byte;
			state_q <= (item == IT_STOP) ? H_STOP
				: (item == IT_RESTART || step_q == 4'd0) ? H_START : H_BYTE;
		end else if (tick) begin
			qtr_q <= qtr_q + 2'd1;
			unique case (state_q)
				H_START: begin
					// Data falls while the clock is high.
					if (qtr_q == 2'd0) sda_oe_q <= 1'b0;
					if (qtr_q == 2'd1) scl_oe_q <= 1'b0;
					if (qtr_q == 2'd2) sda_oe_q <= 1'b1;
					if (qtr_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						if (step_q == 4'd0) begin
							byte_q <= item_byte;
							state_q <= H_BYTE;
						end else begin
							step_q <= step_q + 4'd1;
							state_q <= H_LOAD;
						end
					end
				end
				H_BYTE: begin
					if (qtr_q == 2'd0) begin
						// Set data while the clock is low.
						if (bit_q < 4'd8) begin
							sda_oe_q <= (item == IT_WR) & ~byte_q[7];
						end else begin
							// RULE6 - ack all but the last byte
							sda_oe_q <= item == IT_RD_ACK;
						end
					end
					if (qtr_q == 2'd1) scl_oe_q <= 1'b0;
					if (qtr_q == 2'd2) begin
						if (bit_q < 4'd8) begin
							byte_q <= {byte_q[6:0], sda_q};
						end else if (item == IT_WR && sda_q) begin
							// No ack: stop once the clock is low.
							nack_q <= 1'b1;
						end else if (item != IT_WR) begin
							if (blk && step_q == 4'd4) begin
								rx_cnt_q <= byte_q;
							end else begin
								rx_q[d_idx[1:0] * 8 +: 8] <= byte_q;
							end
						end
					end
					if (qtr_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						bit_q <= bit_q + 4'd1;
						if (bit_q == 4'd8) begin
							step_q <= step_q + 4'd1;
							state_q <= nack_q ? H_STOP : H_LOAD;
						end
					end
				end
				H_STOP: begin
					// RULE8 - data rises while the clock is high
					if (qtr_q == 2'd0) sda_oe_q <= 1'b1;
					if (qtr_q == 2'd1) scl_oe_q <= 1'b0;
					if (qtr_q == 2'd2) sda_oe_q <= 1'b0;
					if (qtr_q == 2'd3) state_q <= H_IDLE;
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	// Open drain outputs: low when enabled.
	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe = scl_oe_q;
	assign link.host_sda_oe = sda_oe_q;
endmodule // ckg_host

// File: test/ckg_props.sv
// Checker of the two-wire link.
`timescale 1ns/1ps
module ckg_props (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_srst,
	// Link signals.
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// Frame tracking.
	logic scl_q, sda_q, match_q, dir_q, cmd7_q;
	logic [3:0] bit_q, byte_q;
	logic [7:0] sh_q;
	logic rise, start, last;
	assign rise = scl && !scl_q;
	assign start = scl && scl_q && sda_q && !sda;
	assign last = rise && bit_q == 4'h8;
	// The ninth clock rise of each byte is the acknowledge.
	always_ff @(posedge i_mclk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (i_srst || start) begin
			bit_q <= 4'h0;
			byte_q <= 4'h0;
		end else if (last) begin
			bit_q <= 4'h0;
			byte_q <= byte_q + 4'h1;
		end else if (rise) begin
			bit_q <= bit_q + 4'h1;
			sh_q <= {sh_q[6:0], sda};
		end
	end
	// Address match, direction and command mode bit.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			match_q <= 1'b0;
			dir_q <= 1'b0;
			cmd7_q <= 1'b0;
		end else if (last && byte_q == 4'h0) begin
			match_q <= sh_q[7:1] == 7'h69;
			dir_q <= sh_q[0];
		end else if (last && byte_q == 4'h1 && !dir_q) begin
			cmd7_q <= sh_q[7];
		end
	end
	reset_idle_a: assert property (disable iff (1'b0)
		i_srst |=> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
		else $error("link held in reset");
	scl_high_a: assert property ($rose(scl) |-> scl [*7])
		else $error("short clock high");
	scl_low_a: assert property ($fell(scl) |-> !scl [*7])
		else $error("short clock low");
	dev_stable_a: assert property ($changed(dev_sda_oe) |->
		!scl && !$past(scl) && !$past(scl, 2))
		else $error("data moved near clock high");
	addr_ack_a: assert property (last && byte_q == 4'h0 |->
		sda == (sh_q[7:1] != 7'h69))
		else $error("bad address ack");
	dev_quiet_a: assert property ((byte_q == 4'h0 && bit_q != 4'h8) ||
		(byte_q != 4'h0 && !match_q) |-> !dev_sda_oe)
		else $error("device drove out of turn");
	write_ack_a: assert property (last && byte_q != 4'h0 &&
		match_q && !dir_q |-> !sda)
		else $error("write byte not acked");
	blk_count_a: assert property (last && byte_q == 4'h1 && match_q &&
		dir_q && !cmd7_q |-> sh_q == ckg_pkg::BLOCK_COUNT)
		else $error("bad block count");
endmodule // ckg_props

// File: test/test_clockgen_serial_config_port.sv
// Bench of host, clock generator and a bit-banged link.
`timescale 1ns/1ps
module test_clockgen_serial_config_port;
	// Clock, reset, APB and skip option.
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, skip = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr;
	// Outputs, model bytes and notes.
	wire logic [18:0] outs;
	logic [18:0] last_outs;
	logic [7:0] r [3];
	logic [65:0] rd_q [$];
	logic [18:0] out_q [$];
	logic [31:0] seed = 32'h11380A7E;
	int error_cnt = 0, checks = 0;
	ckg_if link ();
	ckg_if link2 ();
	ckg_host #(.QUARTER_CYC(4)) ckg_host_i (.i_mclk(i_mclk),
		.i_srst(i_srst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.link(link.host));
	ckg_dev ckg_dev_i (.i_mclk(i_mclk), .i_srst(i_srst), .link(link.dev),
		.i_count_skip(skip), .o_serial_ref_pair_en(outs[18:14]),
		.o_cpu_pair_en(outs[13:10]), .o_crystal_copy_out_en(outs[9:8]),
		.o_bus_clock_en(outs[7:4]), .o_free_running_bus_clock_en(outs[3:1]),
		.o_main_synth_loop_spread(outs[0]));
	// Second device, driven bit by bit by the bench.
	ckg_dev ckg_dev2_i (.i_mclk(i_mclk), .i_srst(i_srst), .link(link2.dev),
		.i_count_skip(1'b0), .o_serial_ref_pair_en(), .o_cpu_pair_en(),
		.o_crystal_copy_out_en(), .o_bus_clock_en(),
		.o_free_running_bus_clock_en(), .o_main_synth_loop_spread());
	ckg_props ckg_props_i (.i_mclk(i_mclk), .i_srst(i_srst),
		.host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
	// Free-running 200 MHz clock.
	initial forever #2.5 i_mclk = ~i_mclk;
	// Pseudo-random data source.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [18:0] exp_outs();
		return {r[0][4:0], r[1][5], r[1][4], r[1][2], r[1][1], r[1][7:6],
			r[2][7:1], r[1][0]};
	endfunction
	function automatic logic [7:0] wm(input int k);
		return k == 0 ? ckg_pkg::WR_SRC : k == 1 ? ckg_pkg::WR_REF_CPU
			: ckg_pkg::WR_PCI;
	endfunction
	// Masked compare of a read word.
	task automatic cmp_rd(input logic [32:0] m, e, g);
		checks++;
		if ((g & m) !== (e & m)) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g & m,
				e & m);
		end
	endtask
	// Compares the device output vector.
	task automatic cmp_out(input logic [18:0] e, g);
		cmp_rd({33{1'b1}}, {14'h0, e}, {14'h0, g});
	endtask
	// Updates one model byte; notes a visible change.
	task automatic put(input int k, input logic [7:0] b);
		logic [18:0] old;
		old = exp_outs();
		r[k] = (r[k] & ~wm(k)) | (b & wm(k));
		if (exp_outs() !== old) out_q.push_back(exp_outs());
	endtask
	// One APB transfer; a read notes its expected word.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] m, e);
		int n = 0;
		if (!w) rd_q.push_back({m, e});
		@(posedge i_mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Runs one serial transfer and polls until idle.
	task automatic xfer(input logic [1:0] op, input logic [7:0] cmd,
		input logic [2:0] len, input logic [31:0] tx, input logic sk);
		int n = 0;
		skip <= sk;
		apb(1'b1, ckg_pkg::HREG_CMD, {21'h0, len, cmd}, '0, '0);
		apb(1'b1, ckg_pkg::HREG_TX, tx, '0, '0);
		apb(1'b1, ckg_pkg::HREG_CTRL, {28'h0, sk, op, 1'b1}, '0, '0);
		do begin
			apb(1'b0, ckg_pkg::HREG_STAT, 32'h0, '0, '0);
			n++;
		end while (rd[0] !== 1'b0 && n < 2000);
	endtask
	// Drives the second link for eight clock cycles, a third of a bit.
	task automatic bb(input logic c, input logic s);
		link2.host_scl_oe <= !c;
		link2.host_sda_oe <= !s;
		repeat (8) @(posedge i_mclk);
	endtask
	// Compares each read with the oldest note.
	always @(posedge i_mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (rd_q.size() != 0) begin
				cmp_rd(rd_q[0][65:33], rd_q[0][32:0], {pslverr, prdata});
				void'(rd_q.pop_front());
			end else error_cnt++;
		end
	end
	// Each output change must match the oldest note.
	always @(posedge i_mclk) begin
		if (i_srst) last_outs <= outs;
		else if (outs !== last_outs) begin
			last_outs <= outs;
			if (out_q.size() != 0) cmp_out(out_q.pop_front(), outs);
			else cmp_out(last_outs, outs);
		end
	end
	// Prints counts and verdict, then ends the run.
	task automatic final_report();
		if (rd_q.size() != 0 || out_q.size() != 0) error_cnt++;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog against a hung transfer.
	initial begin
		repeat (60000) @(posedge i_mclk);
		error_cnt++;
		final_report();
	end
	// Main sequence.
	initial begin
		logic [31:0] d;
		logic [7:0] a;
		link2.host_scl_o = 1'b0;
		link2.host_sda_o = 1'b0;
		link2.host_scl_oe = 1'b0;
		link2.host_sda_oe = 1'b0;
		r = '{8'hFF, 8'hFE, 8'hFF};
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		repeat (8) @(posedge i_mclk);
		cmp_out(exp_outs(), outs);
		apb(1'b0, ckg_pkg::HREG_STAT, 32'h0, {33{1'b1}}, 33'h0);
		apb(1'b0, 8'h14, 32'h0, {33{1'b1}}, {1'b1, 32'h0});
		// Byte writes at every offset, the last one out of range.
		for (int k = 0; k < 4; k++) begin
			d = rnd();
			if (k < 3) put(k, d[7:0]);
			xfer(ckg_pkg::OP_BYTE_WR, 8'h80 | k[7:0], 3'h1, d, 1'b0);
		end
		// Byte reads at every offset.
		for (int k = 0; k < 4; k++) begin
			xfer(ckg_pkg::OP_BYTE_RD, 8'h80 | k[7:0], 3'h1, 32'h0, 1'b0);
			apb(1'b0, ckg_pkg::HREG_RX, 32'h0, {25'h0, 8'hFF},
				{25'h0, k < 3 ? r[k] : 8'h00});
		end
		// Block writes of one to three bytes, with and without count.
		for (int k = 0; k < 3; k++) begin
			d = rnd();
			for (int j = 0; j <= k; j++) put(j, d[8 * j +: 8]);
			xfer(ckg_pkg::OP_BLK_WR, 8'h00, 3'(k + 1), d, k[0]);
		end
		// Block read of four bytes, the last past the control bytes.
		xfer(ckg_pkg::OP_BLK_RD, 8'h00, 3'h4, 32'h0, 1'b0);
		apb(1'b0, ckg_pkg::HREG_RX, 32'h0, {33{1'b1}},
			{9'h0, r[2], r[1], r[0]});
		apb(1'b0, ckg_pkg::HREG_STAT, 32'h0, {17'h0, 16'hFF03},
			{17'h0, 16'h0300});
		// Foreign then own address on the second link.
		for (int k = 0; k < 2; k++) begin
			a = k ? 8'hD2 : 8'hA4;
			bb(1'b1, 1'b1);
			bb(1'b1, 1'b0);
			bb(1'b0, 1'b0);
			for (int i = 7; i >= 0; i--) begin
				bb(1'b0, a[i]);
				bb(1'b1, a[i]);
				bb(1'b0, a[i]);
			end
			bb(1'b0, 1'b1);
			bb(1'b1, 1'b1);
			cmp_rd(33'h1, {32'h0, k == 0}, {32'h0, link2.sda});
			bb(1'b0, 1'b0);
			bb(1'b1, 1'b0);
			bb(1'b1, 1'b1);
		end
		final_report();
	end
endmodule // test_clockgen_serial_config_port
